// file: hw/slave_fifo_port.sv
`timescale 1ns/1ns
module slave_fifo_port
   import slave_fifo_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic interface_clock,
   input wire mode_e port_mode,
   input wire logic auto_mode,
   input wire logic [LEN_W-1:0] auto_commit_length,
   input wire logic [SEL_W-1:0] fifo_select,
   input wire logic port_chip_select_n,
   input wire logic port_output_enable_n,
   input wire logic port_read_strobe_n,
   input wire logic port_write_strobe_n,
   input wire logic packet_commit_strobe_n,
   input wire logic [DATA_W-1:0] port_data_in,
   output logic [DATA_W-1:0] port_data_out,
   output logic port_data_oe,
   output logic fifo_empty,
   output logic fifo_full,
   output logic commit_valid,
   output commit_rec_s commit_rec,
   input wire logic load_valid,
   input wire load_rec_s load_rec,
   output logic load_ready
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);

   // link-domain reset: asserts at once, releases on interface_clock
   logic rst_l1, rst_link, ce_l1, ce_l;
   always_ff @(posedge interface_clock or posedge rst) begin
      if (rst) begin
         rst_l1 <= 1'h1;
         rst_link <= 1'h1;
         ce_l1 <= 1'h0;
         ce_l <= 1'h0;
      end else begin
         rst_l1 <= 1'h0;
         rst_link <= rst_l1;
         ce_l1 <= ce;
         ce_l <= ce_l1;
      end
   end

   // async strobes are unrelated to interface_clock, so they pass three flops
   pin_s pin_raw, pin_s1, pin_s2, pin_s3, cur;
   assign pin_raw = {fifo_select, ~port_chip_select_n, ~port_output_enable_n, ~port_read_strobe_n,
                     ~port_write_strobe_n, ~packet_commit_strobe_n, port_data_in};
   always_ff @(posedge interface_clock or posedge rst_link) begin
      if (rst_link) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   wire is_async = port_mode == MODE_ASYNC;
   assign cur = is_async ? pin_s3 : pin_raw;
   wire [SEL_W-1:0] sel = cur.sel;
   // chip select simply gates every strobe, so a tied-active select works
   wire rd_req = is_async ? (pin_s2.rd & ~pin_s3.rd & pin_s2.cs) : (pin_raw.rd & pin_raw.cs);
   wire wr_req = is_async ? (~pin_s2.wr & pin_s3.wr & pin_s3.cs) : (pin_raw.wr & pin_raw.cs);
   wire pe_req = is_async ? (pin_s2.pe & ~pin_s3.pe & pin_s2.cs) : (pin_raw.pe & pin_raw.cs);
   wire drive = is_async ? (pin_s2.oe & pin_s2.cs) : (pin_raw.oe & pin_raw.cs);
   assign port_data_oe = drive & ~rst_link;

   logic [DATA_W-1:0] mem [FIFO_NUM][DEPTH];
   logic [PTR_W-1:0] wp [FIFO_NUM];
   logic [PTR_W-1:0] rp [FIFO_NUM];
   logic [CNT_W-1:0] cnt [FIFO_NUM];
   logic [CNT_W-1:0] next_cnt [FIFO_NUM];
   logic [LEN_W-1:0] pkt [FIFO_NUM];
   logic [LEN_W-1:0] next_pkt [FIFO_NUM];
   logic [LEN_W-1:0] pend_len [FIFO_NUM];
   logic [FIFO_NUM-1:0] pend, wr_hit, rd_hit, pw_hit, cm_hit, send_hit, full_v, empty_v;

   // load path from the system side (handshake, record held by sender)
   logic ld_req, ld_req_s1, ld_req_s2, ld_ack, ld_ack_s1, ld_ack_s2;
   load_rec_s ld_rec_q;
   // commit path toward the system side
   logic cm_req, cm_req_s1, cm_req_s2, cm_req_s3, cm_ack_l1, cm_ack_l2, cm_any;
   logic [SEL_W-1:0] cm_pick;
   commit_rec_s cm_rec_q;

   wire do_rd = rd_req & ~empty_v[sel];
   wire do_wr = wr_req & ~full_v[sel];
   // a port write wins the cycle; a pending load simply waits
   wire ld_go = (ld_req_s2 != ld_ack) & ~do_wr & ~full_v[ld_rec_q.fifo];
   wire [DATA_W-1:0] wdata = do_wr ? cur.data : ld_rec_q.data;
   wire cm_idle = cm_ack_l2 == cm_req;
   wire cm_start = cm_idle & cm_any & ce_l;

   genvar i;
   generate
      for (i = 0; i < FIFO_NUM; i++) begin : g_fifo
         wire sel_me = sel == SEL_W'(i);
         assign pw_hit[i] = do_wr & sel_me;
         assign wr_hit[i] = pw_hit[i] | (ld_go & (ld_rec_q.fifo == SEL_W'(i)));
         assign rd_hit[i] = do_rd & sel_me;
         assign next_cnt[i] = cnt[i] + CNT_W'(wr_hit[i]) - CNT_W'(rd_hit[i]);
         assign next_pkt[i] = pkt[i] + LEN_W'(pw_hit[i]);
         // word written on the commit edge is already in next_pkt
         assign cm_hit[i] = (pe_req & sel_me) |
                            (auto_mode & pw_hit[i] & (next_pkt[i] >= auto_commit_length));
         assign send_hit[i] = cm_start & (cm_pick == SEL_W'(i));
         assign full_v[i] = cnt[i] == CNT_W'(DEPTH);
         assign empty_v[i] = cnt[i] == '0;

         always_ff @(posedge interface_clock) begin
            if (ce_l && wr_hit[i]) begin
               mem[i][wp[i]] <= wdata;
            end
         end

         always_ff @(posedge interface_clock or posedge rst_link) begin
            if (rst_link) begin
               wp[i] <= '0;
               rp[i] <= '0;
               cnt[i] <= '0;
               pkt[i] <= '0;
               pend[i] <= 1'h0;
               pend_len[i] <= '0;
            end else if (ce_l) begin
               if (wr_hit[i]) begin
                  wp[i] <= wp[i] + PTR_W'(1);
               end
               if (rd_hit[i]) begin
                  rp[i] <= rp[i] + PTR_W'(1);
               end
               cnt[i] <= next_cnt[i];
               pkt[i] <= cm_hit[i] ? '0 : next_pkt[i];
               // a second commit before hand-over merges into the pending one
               if (cm_hit[i]) begin
                  pend[i] <= 1'h1;
                  pend_len[i] <= ((pend[i] && !send_hit[i]) ? pend_len[i] : '0) + next_pkt[i];
               end else if (send_hit[i]) begin
                  pend[i] <= 1'h0;
               end
            end
         end
      end
   endgenerate

   always_comb begin
      cm_pick = '0;
      cm_any = 1'h0;
      for (int j = FIFO_NUM - 1; j >= 0; j--) begin
         if (pend[j]) begin
            cm_pick = SEL_W'(j);
            cm_any = 1'h1;
         end
      end
   end

   wire [PTR_W-1:0] rp_sel = rp[sel];
   wire [DATA_W-1:0] word_now = mem[sel][rp_sel];
   wire [DATA_W-1:0] word_next = mem[sel][rp_sel + PTR_W'(1)];
   wire [CNT_W-1:0] cnt_sel = cnt[sel];
   wire [CNT_W-1:0] next_cnt_sel = next_cnt[sel];

   always_ff @(posedge interface_clock or posedge rst_link) begin
      if (rst_link) begin
         port_data_out <= '0;
         fifo_empty <= 1'h1;
         fifo_full <= 1'h0;
         ld_req_s1 <= 1'h0;
         ld_req_s2 <= 1'h0;
         ld_ack <= 1'h0;
         cm_ack_l1 <= 1'h0;
         cm_ack_l2 <= 1'h0;
         cm_req <= 1'h0;
         cm_rec_q <= '0;
      end else begin
         ld_req_s1 <= ld_req;
         ld_req_s2 <= ld_req_s1;
         cm_ack_l1 <= cm_req_s3;
         cm_ack_l2 <= cm_ack_l1;
         if (ce_l) begin
            // sync mode keeps the word at the pointer prefetched
            if (!is_async) begin
               port_data_out <= do_rd ? word_next : word_now;
            end else if (do_rd) begin
               port_data_out <= word_now;
            end
            // otherwise async output holds the earlier word
            fifo_empty <= next_cnt_sel == '0;
            fifo_full <= next_cnt_sel == CNT_W'(DEPTH);
            if (ld_go) begin
               ld_ack <= ld_req_s2;
            end
            if (cm_start) begin
               cm_rec_q <= '{fifo: cm_pick, len: pend_len[cm_pick]};
               cm_req <= ~cm_req;
            end
         end
      end
   end

   // system side of both handshakes
   assign load_ready = (ld_ack_s2 == ld_req) & ce & ~rst;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ld_req <= 1'h0;
         ld_rec_q <= '0;
         ld_ack_s1 <= 1'h0;
         ld_ack_s2 <= 1'h0;
         cm_req_s1 <= 1'h0;
         cm_req_s2 <= 1'h0;
         cm_req_s3 <= 1'h0;
         commit_valid <= 1'h0;
         commit_rec <= '0;
      end else if (ce) begin
         ld_ack_s1 <= ld_ack;
         ld_ack_s2 <= ld_ack_s1;
         cm_req_s1 <= cm_req;
         cm_req_s2 <= cm_req_s1;
         cm_req_s3 <= cm_req_s2;
         commit_valid <= cm_req_s2 != cm_req_s3;
         if (cm_req_s2 != cm_req_s3) begin
            commit_rec <= cm_rec_q;
         end
         if (load_valid && load_ready) begin
            ld_rec_q <= load_rec;
            ld_req <= ~ld_req;
         end
      end
   end

   default clocking cb @(posedge interface_clock); endclocking
   default disable iff (rst_link || !ce_l);

   property p_cs_read;
      !is_async && !pin_raw.cs |-> !do_rd;
   endproperty
   a_cs_read: assert property (p_cs_read) else $error("read taken without chip select");

   property p_cs_write;
      !is_async && !pin_raw.cs |-> !do_wr;
   endproperty
   a_cs_write: assert property (p_cs_write) else $error("write taken without chip select");

   property p_rd_next;
      !is_async && do_rd |=> port_data_out == $past(word_next);
   endproperty
   a_rd_next: assert property (p_rd_next) else $error("read did not present next word");

   sequence s_burst_rd;
      (!is_async && do_rd && !do_wr && !ld_go && $stable(sel))[*3];
   endsequence
   property p_burst_rd;
      s_burst_rd |=> cnt[$past(sel)] == $past(cnt_sel, 3) - CNT_W'(3);
   endproperty
   a_burst_rd: assert property (p_burst_rd) else $error("burst read lost a word");

   property p_wr_count;
      do_wr && !do_rd |=> cnt[$past(sel)] == $past(cnt_sel) + CNT_W'(1) && !fifo_empty;
   endproperty
   a_wr_count: assert property (p_wr_count) else $error("write did not update count or flag");

   sequence s_burst_wr;
      (!is_async && do_wr && !do_rd && $stable(sel))[*3];
   endsequence
   property p_burst_wr;
      s_burst_wr |=> cnt[$past(sel)] == $past(cnt_sel, 3) + CNT_W'(3);
   endproperty
   a_burst_wr: assert property (p_burst_wr) else $error("burst write lost a word");

   property p_commit;
      pe_req && !pend[sel] |=> pend[$past(sel)] && pkt[$past(sel)] == '0 &&
         pend_len[$past(sel)] == $past(next_pkt[sel]);
   endproperty
   a_commit: assert property (p_commit) else $error("commit length wrong");

   property p_auto;
      auto_mode && do_wr && next_pkt[sel] >= auto_commit_length |=> pend[$past(sel)] && pkt[$past(sel)] == '0;
   endproperty
   a_auto: assert property (p_auto) else $error("auto commit missed");

   property p_async_hold;
      is_async && !do_rd ##1 is_async |-> $stable(port_data_out);
   endproperty
   a_async_hold: assert property (p_async_hold) else $error("async output changed without read");

   property p_async_read;
      is_async && do_rd |=> port_data_out == $past(word_now) && rp[$past(sel)] == $past(rp_sel) + PTR_W'(1);
   endproperty
   a_async_read: assert property (p_async_read) else $error("async read word or pointer wrong");

   property p_async_write;
      is_async && do_wr |=> mem[$past(sel)][$past(wp[sel])] == $past(cur.data);
   endproperty
   a_async_write: assert property (p_async_write) else $error("async write stored wrong word");

   property p_decode;
      do_wr |-> $onehot(wr_hit) && wr_hit[sel];
   endproperty
   a_decode: assert property (p_decode) else $error("write routed to wrong fifo");
endmodule : slave_fifo_port

// file: hw/slave_fifo_pkg.sv
package slave_fifo_pkg;
   localparam int DATA_W = 16;
   localparam int SEL_W = 2;
   localparam int FIFO_NUM = 4;
   localparam int FIFO_DEPTH = 16;
   localparam int LEN_W = 8;
   localparam int SEL_SETUP_NS = 25;
   localparam int INTERFACE_CLOCK_MHZ = 48;

   typedef enum logic [0:0] {
      MODE_SYNC = 1'b0,
      MODE_ASYNC = 1'b1
   } mode_e;

   typedef struct packed {
      logic [SEL_W-1:0] sel;
      logic cs;
      logic oe;
      logic rd;
      logic wr;
      logic pe;
      logic [DATA_W-1:0] data;
   } pin_s;

   typedef struct packed {
      logic [SEL_W-1:0] fifo;
      logic [LEN_W-1:0] len;
   } commit_rec_s;

   typedef struct packed {
      logic [SEL_W-1:0] fifo;
      logic [DATA_W-1:0] data;
   } load_rec_s;
endpackage : slave_fifo_pkg

// file: verif/port_master.sv
`timescale 1ns/1ns
module port_master
   import slave_fifo_pkg::*;
(
   input wire logic interface_clock,
   output pin_s pins
);
   initial begin
      pins = {2'h0, 5'h1f, 16'h0000};
   end

   // one pin state per link edge, held n edges; select stays put across strobes
   task automatic step(input pin_s p, input int n);
      @(posedge interface_clock);
      #1;
      // bus not written shows no stale word
      if (p.wr) begin
         p.data = ~pins.data;
      end
      pins = p;
      // each wait ends just past the edge, so registered outputs have settled
      repeat (n - 1) begin
         @(posedge interface_clock);
         #1;
      end
   endtask : step
endmodule : port_master

// file: verif/slave_fifo_port_tb_top.sv
`timescale 1ns/1ns
module slave_fifo_port_tb_top;
   import slave_fifo_pkg::*;
   // control pins cs, oe, rd, wr, commit, all active low
   localparam logic [4:0] C_IDLE = 5'h0f;
   localparam logic [4:0] C_WR = 5'h0d;
   localparam logic [4:0] C_WR_PE = 5'h0c;
   localparam logic [4:0] C_PE = 5'h0e;
   localparam logic [4:0] C_OE = 5'h07;
   localparam logic [4:0] C_OE_RD = 5'h03;
   localparam logic [4:0] C_NOCS_RD = 5'h13;
   logic clk_sys;
   logic interface_clock;
   logic rst;
   logic ce;
   logic auto_mode;
   logic load_valid;
   mode_e port_mode;
   logic [LEN_W-1:0] auto_commit_length;
   load_rec_s load_rec;
   pin_s pins;
   logic [DATA_W-1:0] port_data_out;
   logic port_data_oe;
   logic fifo_empty;
   logic fifo_full;
   logic commit_valid;
   logic load_ready;
   commit_rec_s commit_rec;
   commit_rec_s seen[$];
   int bad_count;
   int total_checks;

   port_master i_port_master (.interface_clock(interface_clock), .pins(pins));

   slave_fifo_port i_slave_fifo_port (
      .clk_sys(clk_sys), .rst(rst), .ce(ce), .interface_clock(interface_clock),
      .port_mode(port_mode), .auto_mode(auto_mode), .auto_commit_length(auto_commit_length),
      .fifo_select(pins.sel), .port_chip_select_n(pins.cs), .port_output_enable_n(pins.oe),
      .port_read_strobe_n(pins.rd), .port_write_strobe_n(pins.wr), .packet_commit_strobe_n(pins.pe),
      .port_data_in(pins.data), .port_data_out(port_data_out), .port_data_oe(port_data_oe),
      .fifo_empty(fifo_empty), .fifo_full(fifo_full), .commit_valid(commit_valid),
      .commit_rec(commit_rec), .load_valid(load_valid), .load_rec(load_rec), .load_ready(load_ready)
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // 15 ns link clock, offset 3 ns; its rising edges still meet those of clk_sys every 30 ns
   initial begin
      interface_clock = 1'b0;
      #3;
      forever begin
         #7 interface_clock = ~interface_clock;
         #8 interface_clock = ~interface_clock;
      end
   end

   // commit pulses last one cycle, so collect them while the master is busy
   always @(posedge clk_sys) begin
      if (commit_valid === 1'b1) begin
         seen.push_back(commit_rec);
      end
   end

   function automatic pin_s pk(input logic [1:0] s, input logic [4:0] ctl, input logic [15:0] d);
      return {s, ctl, d};
   endfunction : pk

   task automatic check(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic load(input logic [1:0] f, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      #1;
      load_valid = 1'b1;
      load_rec = {f, d};
      while (load_ready !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      check("load_ready", 16'h0001, {15'h0000, load_ready});
      @(posedge clk_sys);
      #1;
      load_valid = 1'b0;
      check("load_taken", 16'h0000, {15'h0000, load_ready});
   endtask : load

   task automatic expect_commit(input logic [1:0] f, input logic [7:0] l);
      int n;
      commit_rec_s r;
      n = 0;
      r = '0;
      while (seen.size() == 0 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      if (seen.size() != 0) begin
         r = seen.pop_front();
      end
      check("commit", {6'h00, f, l}, {6'h00, r});
   endtask : expect_commit

   task automatic t_sync_write;
      i_port_master.step(pk(2'h1, C_IDLE, 16'h0000), 2);
      i_port_master.step(pk(2'h1, C_WR, 16'h1111), 1);
      i_port_master.step(pk(2'h1, C_IDLE, 16'h0000), 1);
      check("empty_after_write", 16'h0000, {15'h0000, fifo_empty});
      i_port_master.step(pk(2'h1, C_WR, 16'h2222), 1);
      i_port_master.step(pk(2'h1, C_WR_PE, 16'h3333), 1);
      i_port_master.step(pk(2'h1, C_IDLE, 16'h0000), 2);
      expect_commit(2'h1, 8'h03);
   endtask : t_sync_write

   task automatic t_sync_read;
      load(2'h2, 16'ha0a0);
      load(2'h2, 16'hb1b1);
      load(2'h2, 16'hc2c2);
      i_port_master.step(pk(2'h2, C_IDLE, 16'h0000), 2);
      i_port_master.step(pk(2'h2, C_OE, 16'h0000), 2);
      check("oe_drive", 16'h0001, {15'h0000, port_data_oe});
      check("prefetch", 16'ha0a0, port_data_out);
      i_port_master.step(pk(2'h2, C_OE_RD, 16'h0000), 1);
      i_port_master.step(pk(2'h2, C_OE_RD, 16'h0000), 1);
      check("read_next", 16'hb1b1, port_data_out);
      i_port_master.step(pk(2'h2, C_NOCS_RD, 16'h0000), 2);
      check("burst_next", 16'hc2c2, port_data_out);
      check("no_cs_drive", 16'h0000, {15'h0000, port_data_oe});
      i_port_master.step(pk(2'h2, C_OE, 16'h0000), 2);
      check("no_cs_read", 16'hc2c2, port_data_out);
      check("not_empty", 16'h0000, {15'h0000, fifo_empty});
   endtask : t_sync_read

   task automatic t_auto;
      i_port_master.step(pk(2'h3, C_IDLE, 16'h0000), 2);
      auto_commit_length = 8'h02;
      auto_mode = 1'b1;
      i_port_master.step(pk(2'h3, C_WR, 16'h4444), 1);
      i_port_master.step(pk(2'h3, C_WR, 16'h5555), 1);
      i_port_master.step(pk(2'h3, C_WR, 16'h6666), 1);
      i_port_master.step(pk(2'h3, C_PE, 16'h0000), 1);
      i_port_master.step(pk(2'h3, C_IDLE, 16'h0000), 2);
      expect_commit(2'h3, 8'h02);
      expect_commit(2'h3, 8'h01);
      auto_mode = 1'b0;
   endtask : t_auto

   task automatic t_async_read;
      i_port_master.step(pk(2'h0, C_IDLE, 16'h0000), 2);
      port_mode = MODE_ASYNC;
      load(2'h0, 16'hd3d3);
      i_port_master.step(pk(2'h0, C_OE, 16'h0000), 4);
      i_port_master.step(pk(2'h0, C_OE_RD, 16'h0000), 3);
      i_port_master.step(pk(2'h0, C_OE, 16'h0000), 8);
      check("async_read", 16'hd3d3, port_data_out);
      check("async_empty", 16'h0001, {15'h0000, fifo_empty});
      i_port_master.step(pk(2'h0, C_OE, 16'h0000), 4);
      check("async_oe_only", 16'hd3d3, port_data_out);
      i_port_master.step(pk(2'h0, C_IDLE, 16'h0000), 4);
      port_mode = MODE_SYNC;
   endtask : t_async_read

   task automatic t_async_write;
      i_port_master.step(pk(2'h0, C_IDLE, 16'h0000), 2);
      port_mode = MODE_ASYNC;
      i_port_master.step(pk(2'h0, C_IDLE, 16'h0000), 4);
      i_port_master.step(pk(2'h0, C_WR, 16'h7777), 3);
      i_port_master.step(pk(2'h0, C_IDLE, 16'h0000), 6);
      check("async_write_flag", 16'h0000, {15'h0000, fifo_empty});
      // commit only after the write strobe has stayed high a while
      i_port_master.step(pk(2'h0, C_PE, 16'h0000), 3);
      i_port_master.step(pk(2'h0, C_IDLE, 16'h0000), 4);
      expect_commit(2'h0, 8'h01);
      port_mode = MODE_SYNC;
   endtask : t_async_write

   task automatic t_full;
      i_port_master.step(pk(2'h0, C_IDLE, 16'h0000), 2);
      i_port_master.step(pk(2'h0, C_OE, 16'h0000), 2);
      check("async_stored", 16'h7777, port_data_out);
      // one write too many: the last edge meets a full fifo and is refused
      i_port_master.step(pk(2'h0, C_WR, 16'h8181), 16);
      check("full_flag", 16'h0001, {15'h0000, fifo_full});
      i_port_master.step(pk(2'h0, C_OE_RD, 16'h0000), 3);
      i_port_master.step(pk(2'h0, C_OE, 16'h0000), 1);
      check("burst_word", 16'h8181, port_data_out);
      check("full_cleared", 16'h0000, {15'h0000, fifo_full});
   endtask : t_full

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   initial begin
      bad_count = 0;
      total_checks = 0;
      rst = 1'b1;
      ce = 1'b1;
      auto_mode = 1'b0;
      auto_commit_length = 8'h00;
      port_mode = MODE_SYNC;
      load_valid = 1'b0;
      load_rec = '0;
      repeat (5) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      repeat (6) @(posedge interface_clock);
      t_sync_write();
      t_sync_read();
      t_auto();
      t_async_read();
      t_async_write();
      t_full();
      final_report();
   end

   // all scenarios finish in a few microseconds
   initial begin
      #100000;
      bad_count++;
      final_report();
   end
endmodule : slave_fifo_port_tb_top
